//--- design/gcps_gate_seq.sv
/*
  gcps_gate_seq: phase sequencer for one gate (one side of one half bridge).
  assumes shared timing and current settings arrive stable from the parent and
  the comparator trip input is already deglitched and synchronous.
*/
`timescale 1ns/1ns
module gcps_gate_seq (
  input  wire logic                              clock,
  input  wire logic                              reset,
  input  wire logic                              pwm,
  input  wire logic                              trip,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]  pre_on_cur,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]  pre_off_cur,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]  on_cur,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]  off_cur,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0] t_on1,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0] t_on2,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0] t_off1,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0] t_off2,
  output logic                                   gate_on,
  output logic [gcps_pkg::GCPS_SEL_W-1:0]       cur_sel,
  output logic [gcps_pkg::GCPS_CUR_W-1:0]       cur_code,
  output logic [2:0]                             phase
);
  import gcps_pkg::*;

  typedef struct packed {
    logic                    dir;
    logic                    pwm_last;
    gcps_phase_e             ph;
    logic [GCPS_TIME_W-1:0]  cnt;
    logic [GCPS_SEL_W-1:0]   sel;
    logic [GCPS_CUR_W-1:0]   code;
  } gcps_gate_s;

  gcps_gate_s st_reg;
  gcps_gate_s st_next;

  // ----------------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------------
  always_comb begin
    logic [GCPS_TIME_W-1:0] t1;
    logic [GCPS_TIME_W-1:0] t2;
    t1 = pwm ? t_on1 : t_off1;
    t2 = pwm ? t_on2 : t_off2;
    st_next = st_reg;
    st_next.pwm_last = pwm;
    if (pwm != st_reg.pwm_last) begin
      // a new edge aborts whatever phase was running
      st_next.dir = pwm;
      st_next.cnt = GCPS_TIME_ZERO;
      if (t1 != GCPS_TIME_ZERO) begin
        st_next.ph = GCPS_ST_PH1;
      end else if (t2 != GCPS_TIME_ZERO) begin
        st_next.ph = GCPS_ST_PH2;
      end else begin
        st_next.ph = GCPS_ST_FULL;
      end
    end else begin
      case (st_reg.ph)
        GCPS_ST_PH1: begin
          st_next.cnt = st_reg.cnt + 8'h01;
          if (st_reg.cnt + 8'h01 >= t1) begin
            st_next.cnt = GCPS_TIME_ZERO;
            st_next.ph  = (t2 != GCPS_TIME_ZERO) ? GCPS_ST_PH2 : GCPS_ST_FULL;
          end
        end
        GCPS_ST_PH2: begin
          st_next.cnt = st_reg.cnt + 8'h01;
          if (st_reg.cnt + 8'h01 >= t2) begin
            st_next.cnt = GCPS_TIME_ZERO;
            st_next.ph  = GCPS_ST_FULL;
          end
        end
        GCPS_ST_FULL: st_next.ph = GCPS_ST_FULL;
        GCPS_ST_HOLD: st_next.ph = GCPS_ST_HOLD;
        default:      st_next.ph = GCPS_ST_HOLD;
      endcase
    end
    // comparator overrides any drive phase, but not a fresh edge
    if (trip && pwm == st_reg.pwm_last) begin
      st_next.ph  = GCPS_ST_HOLD;
      st_next.cnt = GCPS_TIME_ZERO;
    end
    case (st_next.ph)
      GCPS_ST_PH1: begin
        st_next.sel  = GCPS_SEL_PROG;
        st_next.code = st_next.dir ? pre_on_cur : pre_off_cur;
      end
      GCPS_ST_PH2: begin
        st_next.sel  = GCPS_SEL_PROG;
        st_next.code = st_next.dir ? on_cur : off_cur;
      end
      GCPS_ST_FULL: begin
        st_next.sel  = GCPS_SEL_FULL;
        st_next.code = GCPS_CUR_MAX;
      end
      default: begin
        st_next.sel  = GCPS_SEL_HOLD;
        st_next.code = GCPS_CUR_RESET;
      end
    endcase
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      st_reg <= '{dir: 1'b0, pwm_last: 1'b0, ph: GCPS_ST_HOLD, cnt: GCPS_TIME_ZERO,
                  sel: GCPS_SEL_HOLD, code: GCPS_CUR_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign gate_on  = st_reg.dir;
  assign cur_sel  = st_reg.sel;
  assign cur_code = st_reg.code;
  assign phase    = st_reg.ph;

endmodule : gcps_gate_seq

//--- shared/gcps_pkg.sv
/*
  gcps_pkg: phase encodings, current codes, widths and reset values shared by the
  gate current phase sequencer and its per-gate sequencer.
  assumes a single 250 MHz clock domain; timing fields count clock cycles directly.
*/
package gcps_pkg;

  // ----------------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------------
  localparam int unsigned GCPS_CUR_W  = 4;
  localparam int unsigned GCPS_TIME_W = 8;
  localparam int unsigned GCPS_SEL_W  = 3;
  localparam int unsigned GCPS_NPH    = 3;

  // ----------------------------------------------------------------------------
  // clock and timer resolution
  // ----------------------------------------------------------------------------
  localparam int unsigned GCPS_CLK_PERIOD_NS  = 4;
  localparam int unsigned GCPS_TICK_NS        = 4;
  localparam int unsigned GCPS_CYC_PER_TICK   = (GCPS_TICK_NS + GCPS_CLK_PERIOD_NS - 1) / GCPS_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------------
  // current source selector driven to the analog gate stage
  // ----------------------------------------------------------------------------
  localparam logic [GCPS_SEL_W-1:0] GCPS_SEL_HOLD = 3'h0;
  localparam logic [GCPS_SEL_W-1:0] GCPS_SEL_PROG = 3'h1;
  localparam logic [GCPS_SEL_W-1:0] GCPS_SEL_FULL = 3'h2;

  // full strength code, 1.5 A peak
  localparam logic [GCPS_CUR_W-1:0] GCPS_CUR_MAX   = 4'hf;
  localparam logic [GCPS_CUR_W-1:0] GCPS_CUR_RESET = 4'h0;
  localparam logic [GCPS_TIME_W-1:0] GCPS_TIME_ZERO = 8'h00;

  // ----------------------------------------------------------------------------
  // phase state, gray along idle->p1->p2->full->hold
  // ----------------------------------------------------------------------------
  typedef enum logic [2:0] {
    GCPS_ST_HOLD = 3'h0,
    GCPS_ST_PH1  = 3'h1,
    GCPS_ST_PH2  = 3'h3,
    GCPS_ST_FULL = 3'h2
  } gcps_phase_e;

endpackage : gcps_pkg

//--- design/gcps_top.sv
/*
  gcps_top: gate current phase sequencer for three half bridges (six gates).
  assumes pwm inputs and comparator flags are synchronous to clock; settings are
  plain ports held stable by the configuration logic outside.
*/
`timescale 1ns/1ns
module gcps_top (
  input  wire logic                                     clock,
  input  wire logic                                     reset,
  input  wire logic [gcps_pkg::GCPS_NPH-1:0]           high_side_pwm_input,
  input  wire logic [gcps_pkg::GCPS_NPH-1:0]           low_side_pwm_input,
  input  wire logic [gcps_pkg::GCPS_NPH-1:0]           high_side_compare_trip,
  input  wire logic [gcps_pkg::GCPS_NPH-1:0]           low_side_compare_trip,
  input  wire logic                                     precurrent_enable,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]         precharge_current,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]         predischarge_current,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]         high_side_turn_on_current,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]         high_side_turn_off_current,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]         low_side_turn_on_current,
  input  wire logic [gcps_pkg::GCPS_CUR_W-1:0]         low_side_turn_off_current,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0]        turn_on_phase1_time,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0]        turn_on_phase2_time,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0]        turn_off_phase1_time,
  input  wire logic [gcps_pkg::GCPS_TIME_W-1:0]        turn_off_phase2_time,
  output logic [gcps_pkg::GCPS_NPH-1:0]                high_gate_on,
  output logic [gcps_pkg::GCPS_NPH-1:0]                low_gate_on,
  output logic [gcps_pkg::GCPS_NPH*gcps_pkg::GCPS_SEL_W-1:0] high_cur_sel,
  output logic [gcps_pkg::GCPS_NPH*gcps_pkg::GCPS_SEL_W-1:0] low_cur_sel,
  output logic [gcps_pkg::GCPS_NPH*gcps_pkg::GCPS_CUR_W-1:0] high_cur_code,
  output logic [gcps_pkg::GCPS_NPH*gcps_pkg::GCPS_CUR_W-1:0] low_cur_code,
  output logic [gcps_pkg::GCPS_NPH*3-1:0]              high_phase,
  output logic [gcps_pkg::GCPS_NPH*3-1:0]              low_phase
);
  import gcps_pkg::*;

  // ----------------------------------------------------------------------------
  // shared pre-phase currents
  // ----------------------------------------------------------------------------
  logic [GCPS_CUR_W-1:0] pre_on_cur;
  logic [GCPS_CUR_W-1:0] pre_off_cur;

  // disabled pre-current falls back to full strength
  assign pre_on_cur  = precurrent_enable ? precharge_current : GCPS_CUR_MAX;
  assign pre_off_cur = precurrent_enable ? predischarge_current : GCPS_CUR_MAX;

  // ----------------------------------------------------------------------------
  // six gate sequencers, all sharing one set of times and pre-currents; turn on/off currents per side
  // ----------------------------------------------------------------------------
  // outputs of the leaf come straight from its state register
  genvar g;
  generate
    for (g = 0; g < GCPS_NPH; g++) begin : g_phase
      gcps_gate_seq u_high (
        .clock       (clock),
        .reset       (reset),
        .pwm         (high_side_pwm_input[g]),
        .trip        (high_side_compare_trip[g]),
        .pre_on_cur  (pre_on_cur),
        .pre_off_cur (pre_off_cur),
        .on_cur      (high_side_turn_on_current),
        .off_cur     (high_side_turn_off_current),
        .t_on1       (turn_on_phase1_time),
        .t_on2       (turn_on_phase2_time),
        .t_off1      (turn_off_phase1_time),
        .t_off2      (turn_off_phase2_time),
        .gate_on     (high_gate_on[g]),
        .cur_sel     (high_cur_sel[g*GCPS_SEL_W +: GCPS_SEL_W]),
        .cur_code    (high_cur_code[g*GCPS_CUR_W +: GCPS_CUR_W]),
        .phase       (high_phase[g*3 +: 3])
      );
      gcps_gate_seq u_low (
        .clock       (clock),
        .reset       (reset),
        .pwm         (low_side_pwm_input[g]),
        .trip        (low_side_compare_trip[g]),
        .pre_on_cur  (pre_on_cur),
        .pre_off_cur (pre_off_cur),
        .on_cur      (low_side_turn_on_current),
        .off_cur     (low_side_turn_off_current),
        .t_on1       (turn_on_phase1_time),
        .t_on2       (turn_on_phase2_time),
        .t_off1      (turn_off_phase1_time),
        .t_off2      (turn_off_phase2_time),
        .gate_on     (low_gate_on[g]),
        .cur_sel     (low_cur_sel[g*GCPS_SEL_W +: GCPS_SEL_W]),
        .cur_code    (low_cur_code[g*GCPS_CUR_W +: GCPS_CUR_W]),
        .phase       (low_phase[g*3 +: 3])
      );
    end
  endgenerate

endmodule : gcps_top

//--- tb/gcps_props.sv
/* gcps_props: assertions on the phase 0 gates of the sequencer.
   assumes only gcps_top ports; bound to it below. */
`timescale 1ns/1ns
module gcps_props (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic [2:0]  high_side_pwm_input,
  input wire logic [2:0]  high_side_compare_trip,
  input wire logic [2:0]  high_gate_on,
  input wire logic [2:0]  low_gate_on,
  input wire logic        precurrent_enable,
  input wire logic [3:0]  precharge_current,
  input wire logic [3:0]  predischarge_current,
  input wire logic [3:0]  high_side_turn_on_current,
  input wire logic [7:0]  turn_on_phase1_time,
  input wire logic [7:0]  turn_on_phase2_time,
  input wire logic [8:0]  high_cur_sel,
  input wire logic [11:0] high_cur_code,
  input wire logic [11:0] low_cur_code,
  input wire logic [8:0]  high_phase,
  input wire logic [8:0]  low_phase
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  sequence s_ph1_to_ph2;
    high_phase[2:0] == 3'h1 && high_gate_on[0] ##1 high_phase[2:0] == 3'h3 && high_gate_on[0];
  endsequence
  sequence s_ph1_two;
    $rose(high_gate_on[0]) && high_phase[2:0] == 3'h1 && turn_on_phase1_time == 8'h02
    ##1 high_phase[2:0] == 3'h1 && high_gate_on[0] && high_side_pwm_input[0] && !high_side_compare_trip[0] &&
      turn_on_phase1_time == 8'h02;
  endsequence
  property p_take;
    high_side_pwm_input[0] != high_gate_on[0] |=>
      high_gate_on[0] == $past(high_side_pwm_input[0]) && high_phase[2:0] != 3'h0;
  endproperty
  property p_pre_on;
    $rose(high_gate_on[0]) && high_phase[2:0] == 3'h1 |->
      high_cur_code[3:0] == ($past(precurrent_enable) ? $past(precharge_current) : 4'hf);
  endproperty
  property p_pre_off;
    $fell(low_gate_on[0]) && low_phase[2:0] == 3'h1 |->
      low_cur_code[3:0] == ($past(precurrent_enable) ? $past(predischarge_current) : 4'hf);
  endproperty
  property p_full;
    high_phase[2:0] == 3'h2 |-> high_cur_sel[2:0] == 3'h2 && high_cur_code[3:0] == 4'hf;
  endproperty
  property p_trip;
    high_side_compare_trip[0] && high_side_pwm_input[0] == high_gate_on[0] |=>
      high_phase[2:0] == 3'h0 && high_cur_sel[2:0] == 3'h0 && high_cur_code[3:0] == 4'h0;
  endproperty
  property p_skip;
    high_side_pwm_input[0] && !high_gate_on[0] && turn_on_phase1_time == 8'h00 &&
      turn_on_phase2_time != 8'h00 |=> high_phase[2:0] == 3'h3;
  endproperty
  property p_src;
    s_ph1_to_ph2 |-> high_cur_code[3:0] == $past(high_side_turn_on_current);
  endproperty
  property p_ph1_len;
    s_ph1_two |=> high_phase[2:0] != 3'h1;
  endproperty
  a_take: assert property (p_take) else $error("pwm edge not taken");
  a_pre_on: assert property (p_pre_on) else $error("precharge code wrong");
  a_pre_off: assert property (p_pre_off) else $error("predischarge code wrong");
  a_full: assert property (p_full) else $error("full phase not max");
  a_trip: assert property (p_trip) else $error("trip did not hold");
  a_skip: assert property (p_skip) else $error("zero phase not skipped");
  a_src: assert property (p_src) else $error("source current wrong");
  a_ph1_len: assert property (p_ph1_len) else $error("phase one too long");
endmodule : gcps_props
bind gcps_top gcps_props i_props (.clock, .reset, .high_side_pwm_input, .high_side_compare_trip,
  .high_gate_on, .low_gate_on, .precurrent_enable, .precharge_current, .predischarge_current,
  .high_side_turn_on_current, .turn_on_phase1_time, .turn_on_phase2_time, .high_cur_sel,
  .high_cur_code, .low_cur_code, .high_phase, .low_phase);

//--- tb/gcps_gate_model.sv
/* gcps_gate_model: three mosfet gates with their gate-source comparators.
   assumes sel and code from one side of gcps_top; slow divides the charge rate. */
`timescale 1ns/1ns
module gcps_gate_model (
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic [1:0]  slow,
  input  wire logic [2:0]  gate_on,
  input  wire logic [8:0]  cur_sel,
  input  wire logic [11:0] cur_code,
  output logic [2:0]       trip
);
  int v [3];
  // hold current keeps the gate where it is
  always @(posedge clock or posedge reset)
    for (int i = 0; i < 3; i++)
      if (reset) v[i] <= 0;
      else if (cur_sel[i*3+:3] != 3'h0)
        v[i] <= gate_on[i] ? v[i] + (int'(cur_code[i*4+:4]) + 1 >> slow) + 1 :
                v[i] - (int'(cur_code[i*4+:4]) + 1 >> slow) - 1;
  always_comb
    for (int i = 0; i < 3; i++)
      trip[i] = gate_on[i] ? v[i] >= 240 : v[i] <= 15;
endmodule : gcps_gate_model

//--- tb/gcps_top_test.sv
/* gcps_top_test: random pwm traffic on six gates scored each cycle against an
   integer model; assumes gcps_gate_model as the gates and gcps_props bound. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin num_errors++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, s); end end
module gcps_top_test;
  import gcps_pkg::*;
  logic clock = 0, reset = 1, precurrent_enable = 0;
  logic [1:0] slow = 0;
  logic [2:0] high_side_pwm_input = 0, low_side_pwm_input = 0, high_side_compare_trip, low_side_compare_trip;
  logic [2:0] high_gate_on, low_gate_on;
  logic [3:0] precharge_current = 0, predischarge_current = 0, high_side_turn_on_current = 0;
  logic [3:0] high_side_turn_off_current = 0, low_side_turn_on_current = 0, low_side_turn_off_current = 0;
  logic [7:0] turn_on_phase1_time = 0, turn_on_phase2_time = 0, turn_off_phase1_time = 0, turn_off_phase2_time = 0;
  logic [8:0] high_cur_sel, low_cur_sel, high_phase, low_phase;
  logic [11:0] high_cur_code, low_cur_code;
  int num_errors = 0, checks = 0, st[6], cnt[6], dr[6], ec[6], a, b;
  wire [5:0] pw = {low_side_pwm_input, high_side_pwm_input};
  wire [5:0] tr = {low_side_compare_trip, high_side_compare_trip};
  wire [5:0] on = {low_gate_on, high_gate_on};
  wire [17:0] ph = {low_phase, high_phase};
  wire [17:0] sl = {low_cur_sel, high_cur_sel};
  wire [23:0] cd = {low_cur_code, high_cur_code};
  gcps_top i_dut (.clock, .reset, .high_side_pwm_input, .low_side_pwm_input, .high_side_compare_trip,
    .low_side_compare_trip, .precurrent_enable, .precharge_current, .predischarge_current,
    .high_side_turn_on_current, .high_side_turn_off_current, .low_side_turn_on_current,
    .low_side_turn_off_current, .turn_on_phase1_time, .turn_on_phase2_time, .turn_off_phase1_time,
    .turn_off_phase2_time, .high_gate_on, .low_gate_on, .high_cur_sel, .low_cur_sel, .high_cur_code,
    .low_cur_code, .high_phase, .low_phase);
  gcps_gate_model i_high (.clock, .reset, .slow, .gate_on(high_gate_on), .cur_sel(high_cur_sel),
    .cur_code(high_cur_code), .trip(high_side_compare_trip));
  gcps_gate_model i_low (.clock, .reset, .slow, .gate_on(low_gate_on), .cur_sel(low_cur_sel),
    .cur_code(low_cur_code), .trip(low_side_compare_trip));
  initial forever #2 clock = ~clock;
  // ----------------------------------------------------------------------------
  // reference model, phase codes as the package: 0 hold 1 pre 3 side 2 full
  // ----------------------------------------------------------------------------
  always @(posedge clock or posedge reset)
    for (int g = 0; g < 6; g++) begin
      a = pw[g] ? turn_on_phase1_time : turn_off_phase1_time;
      b = pw[g] ? turn_on_phase2_time : turn_off_phase2_time;
      if (reset) begin st[g] = 0; dr[g] = 0; cnt[g] = 0; end
      else if (pw[g] != dr[g]) begin dr[g] = pw[g]; st[g] = a ? 1 : b ? 3 : 2; cnt[g] = a ? a : b; end
      else if (tr[g]) st[g] = 0;
      else if (st[g] == 1 && cnt[g] == 1) begin st[g] = b ? 3 : 2; cnt[g] = b; end
      else if (st[g] == 3 && cnt[g] == 1) st[g] = 2;
      else cnt[g]--;
      ec[g] = st[g] == 2 ? 15 : st[g] == 0 ? 0 : st[g] == 1 ? (!precurrent_enable ? 15 :
              dr[g] ? precharge_current : predischarge_current) : g < 3 ? (dr[g] ?
              high_side_turn_on_current : high_side_turn_off_current) : (dr[g] ?
              low_side_turn_on_current : low_side_turn_off_current);
    end
  always @(negedge clock)
    if (!reset)
      for (int g = 0; g < 6; g++) begin
        `CHK("phase", st[g], ph[g*3+:3])
        `CHK("select", st[g] == 0 ? 0 : st[g] == 2 ? 2 : 1, sl[g*3+:3])
        `CHK("code", ec[g], cd[g*4+:4])
        `CHK("gate", dr[g], on[g])
      end
  task give_verdict();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (3000) @(posedge clock);
    num_errors++;
    give_verdict();
  end
  // settings change only once every gate has left its timed phases
  initial begin
    void'($urandom(98690));
    repeat (2) @(posedge clock);
    reset <= 0;
    for (int k = 0; k < 12; k++) begin
      @(posedge clock);
      turn_on_phase1_time <= k == 0 ? 8'h02 : k == 1 ? 8'h00 : 8'($urandom % 6);
      turn_on_phase2_time <= k == 2 ? 8'h00 : 8'($urandom % 5 + 1);
      turn_off_phase1_time <= 8'($urandom % 6);
      turn_off_phase2_time <= 8'($urandom % 6);
      {precharge_current, predischarge_current, high_side_turn_on_current, high_side_turn_off_current,
        low_side_turn_on_current, low_side_turn_off_current} <= 24'($urandom);
      precurrent_enable <= k[0];
      slow <= 2'($urandom);
      repeat (40) begin
        @(posedge clock);
        {low_side_pwm_input, high_side_pwm_input} <= pw ^ 6'($urandom & $urandom);
      end
      repeat (40) @(posedge clock);
      $display("test %0d done, errors %0d", k, num_errors);
    end
    give_verdict();
  end
endmodule : gcps_top_test
